// ### dv/acb_core_props.sv
// timing checks on the execute core fetch, data file and bus ports
// assumes clk_en and run stay high while an instruction is in flight
`timescale 1ns/10ps
`default_nettype none
module acb_core_props
  import acb_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // fetch path
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr_word,
  input  wire logic              instr_ready,
  input  wire logic [PC_W-1:0]   pc,
  // data file and bus
  input  wire acb_df_req_t       df_req,
  input  wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [1:0]        s_axi_bresp
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic        take;
  logic        lit;
  logic        fop;
  logic [15:0] word_q;
  assign take = instr_valid && instr_ready && clk_en;
  assign lit  = instr_word[15:8] inside {OPC_ADD_LIT, OPC_AND_LIT,
                                         OPC_BR_CARRY};
  assign fop  = instr_word[15:10] inside {OPC_ADD_FILE, OPC_ADD_CARRY,
                                          OPC_AND_FILE};
  always_ff @(posedge aclk) begin
    if (take) begin
      word_q <= instr_word;
    end
  end
  sequence s_busy;
    !instr_ready [*3];
  endsequence
  sequence s_idle_cycle;
    !instr_ready [*4] ##1 instr_ready;
  endsequence
  property p_busy;
    take |=> s_busy ##1 (instr_ready or s_idle_cycle);
  endproperty
  property p_one_cycle;
    take && instr_word[15:8] != OPC_BR_CARRY |=> s_busy ##1 instr_ready;
  endproperty
  property p_pc_inc;
    take |=> pc == $past(pc) + PC_STEP;
  endproperty
  property p_lit_nowr;
    take && lit |=> !df_req.wr_en [*4];
  endproperty
  property p_dest_acc;
    take && fop && !instr_word[DEST_BIT] |=> !df_req.wr_en [*4];
  endproperty
  property p_dest_file;
    take && fop && instr_word[DEST_BIT] |-> ##3 df_req.wr_en
      ##1 !df_req.wr_en;
  endproperty
  property p_access;
    take && fop && !instr_word[ACCESS_BIT] |=> df_req.addr ==
      {word_q[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK, word_q[7:0]};
  endproperty
  property p_addr_low;
    take && fop |=> df_req.addr[7:0] == word_q[7:0];
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_busy: assert property (p_busy)
    else $error("fetch accepted during a busy quarter");
  a_one_cycle: assert property (p_one_cycle)
    else $error("single cycle op not ready after four quarters");
  a_pc_inc: assert property (p_pc_inc)
    else $error("pc did not step by one word");
  a_lit_nowr: assert property (p_lit_nowr)
    else $error("literal op wrote the data file");
  a_dest_acc: assert property (p_dest_acc)
    else $error("file op with dest 0 wrote the data file");
  a_dest_file: assert property (p_dest_file)
    else $error("file op with dest 1 missed its q4 write pulse");
  a_access: assert property (p_access)
    else $error("access bank address wrong");
  a_addr_low: assert property (p_addr_low)
    else $error("file address low byte wrong");
  a_bhold: assert property (p_bhold)
    else $error("write response dropped before bready");
endmodule : acb_core_props
bind acb_core acb_core_props props_u (
  .aclk         (aclk),
  .aresetn      (aresetn),
  .clk_en       (clk_en),
  .instr_valid  (instr_valid),
  .instr_word   (instr_word),
  .instr_ready  (instr_ready),
  .pc           (pc),
  .df_req       (df_req),
  .s_axi_bvalid (s_axi_bvalid),
  .s_axi_bready (s_axi_bready),
  .s_axi_bresp  (s_axi_bresp)
);
`default_nettype wire

// ### dv/acb_far_model.sv
// fetch path and data register file model facing the execute core
// assumes the bench picks each word to offer; the file answers at once
`timescale 1ns/10ps
`default_nettype none
module acb_far_model
  import acb_pkg::*;
(
  // clock
  input  wire logic          aclk,
  // bench side
  input  wire logic          offer,
  input  wire logic [15:0]   word,
  // core side
  output logic               instr_valid,
  output logic      [15:0]   instr_word,
  input  wire acb_df_req_t   df_req,
  output logic      [7:0]    df_rd_data
);
  logic [7:0] mem [0:4095];
  assign instr_valid = offer;
  // scrambled while not offered, so a late sample cannot pass
  assign instr_word  = offer ? word : ~word;
  assign df_rd_data  = mem[df_req.addr];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i * 37 + 5);
    end
  end
  always @(posedge aclk) begin
    if (df_req.wr_en) begin
      mem[df_req.addr] <= df_req.wr_data;
    end
  end
endmodule : acb_far_model
`default_nettype wire

// ### dv/add_and_carry_branch_exec_tb.sv
// self-checking bench for the execute core: random and corner opcodes
// assumes acb_far_model as fetch/file partner and the bound checker
`timescale 1ns/10ps
`default_nettype none
module add_and_carry_branch_exec_tb
  import acb_pkg::*;
;
  logic            aclk = 1'b0;
  logic            aresetn = 1'b0;
  logic            offer = 1'b0;
  logic [15:0]     word = 16'h0000;
  logic            awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic            ce = 1'b1;
  logic [3:0]      ws = 4'hf;
  logic [7:0]      awa = 8'h00, ara = 8'h00;
  logic [31:0]     wd = 32'h0, rd;
  logic            ivalid, iready, awr, wrdy, bv, arr, rv;
  logic [15:0]     iword;
  logic [PC_W-1:0] pc, epc;
  acb_df_req_t     dreq;
  logic [7:0]      drd, acc;
  logic [1:0]      br, rr;
  logic [4:0]      fl;
  logic [3:0]      bank;
  int              fails = 0, n_compared = 0, wdog = 0;
  always #2 aclk = ~aclk;
  acb_far_model far_u (.aclk(aclk), .offer(offer), .word(word),
    .instr_valid(ivalid), .instr_word(iword), .df_req(dreq),
    .df_rd_data(drd));
  acb_core dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .instr_valid(ivalid), .instr_word(iword), .instr_ready(iready),
    .pc(pc), .df_req(dreq), .df_rd_data(drd),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd),
    .s_axi_rresp(rr));
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  task automatic tick();
    @(posedge aclk);
    wdog++;
    if (wdog > 40) begin
      fails++;
      print_verdict();
    end
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    // a late bready makes the response wait a cycle
    bre <= 1'($urandom());
    wdog = 0;
    do begin
      tick();
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv && !bre) bre <= 1'b1;
    end while (!(bv && bre));
    r = br;
    bre <= 1'b0;
    tick();
  endtask : axi_wr
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e,
                            input string nm);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    wdog = 0;
    do begin
      tick();
      if (arr) arv <= 1'b0;
    end while (!rv);
    chk(nm, e, rd);
    chk("read resp", {30'h0, RESP_OKAY}, {30'h0, rr});
    rre <= 1'b0;
    tick();
  endtask : expect_reg
  // sum or and with flags {n,ov,z,dc,c}; and keeps ov, dc and c
  function automatic logic [12:0] alu(input logic [7:0] a, b,
                                      input logic ci, is_and);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    s = a + b + ci;
    h = a[3:0] + b[3:0] + ci;
    l = a[6:0] + b[6:0] + ci;
    if (is_and) begin
      return {a & b, a[7] & b[7], fl[3], (a & b) == 8'h00, fl[1:0]};
    end
    return {s[7:0], s[7], l[7] ^ s[8], s[7:0] == 8'h00, h[4], s[8]};
  endfunction : alu
  task automatic run_op(input logic [15:0] w);
    logic [11:0] fa;
    logic [7:0]  fv;
    logic [7:0]  me;
    logic [12:0] r;
    logic        fop;
    offer <= 1'b1;
    word <= w;
    if (w[1]) begin
      // frozen core must leave the offered word untaken
      ce <= 1'b0;
      repeat (3) tick();
      chk("frozen pc", {11'h0, epc}, {11'h0, pc});
      ce <= 1'b1;
    end
    fa = {w[8] ? bank : (w[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK), w[7:0]};
    fv = far_u.mem[fa];
    me = fv;
    fop = w[15:10] inside {OPC_ADD_FILE, OPC_ADD_CARRY, OPC_AND_FILE};
    r = alu(acc, fop ? fv : w[7:0], w[15:10] == OPC_ADD_CARRY && fl[0],
            w[15:8] == OPC_AND_LIT || w[15:10] == OPC_AND_FILE);
    epc = epc + 21'h2;
    if (fop || w[15:8] inside {OPC_ADD_LIT, OPC_AND_LIT}) begin
      fl = r[4:0];
      if (fop && w[DEST_BIT]) me = r[12:5];
      else acc = r[12:5];
    end else if (w[15:8] == OPC_BR_CARRY && fl[0]) begin
      epc = epc + {{12{w[7]}}, w[7:0], 1'b0};
    end
    wdog = 0;
    do tick(); while (!iready);
    offer <= 1'b0;
    // long enough for a taken branch and its idle cycle
    repeat (8) tick();
    expect_reg(OFS_ACC, {24'h0, acc}, "acc");
    expect_reg(OFS_STATUS, {27'h0, fl}, "flags");
    expect_reg(OFS_PC, {11'h0, epc}, "pc");
    chk("file", {24'h0, me}, {24'h0, far_u.mem[fa]});
  endtask : run_op
  initial begin
    logic [7:0]  ofs [6];
    logic [15:0] pat [7];
    logic [15:0] crn [4];
    logic [15:0] w;
    logic [1:0]  r;
    int          k;
    ofs = '{OFS_CTRL, OFS_STATUS, OFS_ACC, OFS_BANK, OFS_PC, OFS_RETIRED};
    pat = '{16'h0f00, 16'h0b00, 16'he200, 16'h2400, 16'h2000, 16'h1400,
            16'hff00};
    crn = '{16'he280, 16'he27f, 16'h0f15, 16'h2100};
    k = $urandom(32'hb93a);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (ofs[i]) expect_reg(ofs[i], {31'h0, i == 0}, "reset value");
    axi_wr(8'h18, 32'h1, r);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(OFS_RETIRED, 32'h5, r);
    chk("retired write", {30'h0, RESP_OKAY}, {30'h0, r});
    expect_reg(OFS_RETIRED, 32'h0, "retired kept");
    axi_wr(OFS_CTRL, 32'h0, r);
    chk("halted ready", 32'h0, {31'h0, iready});
    axi_wr(OFS_CTRL, 32'h1, r);
    // only byte lane 1 may land in the pc
    ws <= 4'h2;
    axi_wr(OFS_PC, 32'h12345678, r);
    ws <= 4'hf;
    expect_reg(OFS_PC, 32'h00005600, "strobed pc");
    $display("test registers done");
    epc = 21'h005600;
    for (int i = 0; i < 60; i++) begin
      k = $urandom_range(6);
      w = pat[k] | (16'($urandom()) & (k > 2 && k < 6 ? 16'h03ff : 16'h00ff));
      acc = 8'($urandom());
      fl = 5'($urandom());
      bank = 4'($urandom());
      // offsets at both range ends, the walk literal, carry-in add
      if (i < 4) begin
        w = crn[i];
        fl = 5'h01;
      end
      axi_wr(OFS_ACC, {24'h0, acc}, r);
      axi_wr(OFS_STATUS, {27'h0, fl}, r);
      axi_wr(OFS_BANK, {28'h0, bank}, r);
      run_op(w);
      $display("test op %0d word %h done", i, w);
    end
    expect_reg(OFS_RETIRED, 32'h0000003c, "retired count");
    print_verdict();
  end
endmodule : add_and_carry_branch_exec_tb
`default_nettype wire

// ### src/acb_alu.sv
// 8-bit adder/and unit with status flag generation
// assumes purely combinational use from the execute core
`timescale 1ns/10ps
`default_nettype none
module acb_alu
  import acb_pkg::*;
(
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       op_and,
  // results
  output logic      [7:0] result,
  output acb_flags_t      flags,
  output acb_flags_t      upd
);

  logic [8:0] sum9;
  logic [4:0] low5;

  always_comb begin
    sum9   = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low5   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    result = op_and ? (a & b) : sum9[7:0];
    flags.c  = sum9[8];
    flags.dc = low5[4];
    flags.z  = (result == 8'h00);
    flags.n  = result[7];
    flags.ov = (a[7] == b[7]) && (sum9[7] != a[7]);
    // logic ops touch only negative and zero
    upd = op_and ? 5'b10100 : 5'b11111;
  end

endmodule : acb_alu
`default_nettype wire

// ### src/acb_core.sv
// execute core for add, and, add-with-carry and branch-on-carry
// assumes fetch and data file logic on aclk, axi4-lite master on aclk
`timescale 1ns/10ps
`default_nettype none
module acb_core
  import acb_pkg::*;
(
  // clock, reset, enable
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clk_en,
  // fetch path
  input  wire logic               instr_valid,
  input  wire logic [15:0]        instr_word,
  output logic                    instr_ready,
  output logic      [PC_W-1:0]    pc,
  // data register file
  output acb_df_req_t             df_req,
  input  wire logic [7:0]         df_rd_data,
  // axi4-lite write address
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  // axi4-lite write data
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  // axi4-lite write response
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic      [1:0]         s_axi_bresp,
  // axi4-lite read address
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [AXI_AW-1:0]  s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  // axi4-lite read data
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic      [31:0]        s_axi_rdata,
  output logic      [1:0]         s_axi_rresp
);

  typedef struct packed {
    acb_phase_t         phase;
    logic               idle_cyc;
    logic               take;
    logic [15:0]        ir;
    logic [7:0]         opnd;
    logic [7:0]         acc;
    acb_flags_t         flags;
    logic [3:0]         bank;
    logic [PC_W-1:0]    pc;
    logic               run;
    logic [31:0]        retired;
    acb_df_req_t        df;
    logic               aw_held;
    logic [AXI_AW-1:0]  aw_addr;
    logic               w_held;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } acb_core_state_t;

  localparam acb_core_state_t RST_STATE = '{
    phase:    PH_Q1,
    idle_cyc: 1'b0,
    take:     1'b0,
    ir:       16'h0000,
    opnd:     8'h00,
    acc:      RST_ACC,
    flags:    5'h00,
    bank:     RST_BANK,
    pc:       RST_PC,
    run:      RST_RUN,
    retired:  32'h00000000,
    df:       '0,
    aw_held:  1'b0,
    aw_addr:  8'h00,
    w_held:   1'b0,
    w_data:   32'h00000000,
    w_strb:   4'h0,
    bvalid:   1'b0,
    bresp:    RESP_OKAY,
    rvalid:   1'b0,
    rdata:    32'h00000000,
    rresp:    RESP_OKAY
  };

  acb_core_state_t q;
  acb_core_state_t d;

  // decode of the instruction held for the current cycle
  logic       is_add_lit;
  logic       is_and_lit;
  logic       is_add_file;
  logic       is_add_carry;
  logic       is_and_file;
  logic       is_br_carry;
  logic       is_file_op;
  logic       is_lit_op;
  logic       alu_and;
  logic [7:0] alu_res;
  acb_flags_t alu_flags;
  acb_flags_t alu_upd;

  always_comb begin
    is_add_lit   = (q.ir[15:8] == OPC_ADD_LIT);
    is_and_lit   = (q.ir[15:8] == OPC_AND_LIT);
    is_br_carry  = (q.ir[15:8] == OPC_BR_CARRY);
    is_add_file  = (q.ir[15:10] == OPC_ADD_FILE);
    is_add_carry = (q.ir[15:10] == OPC_ADD_CARRY);
    is_and_file  = (q.ir[15:10] == OPC_AND_FILE);
    is_file_op   = is_add_file | is_add_carry | is_and_file;
    is_lit_op    = is_add_lit | is_and_lit;
    alu_and      = is_and_lit | is_and_file;
  end

  acb_alu u_alu (
    .a      (q.acc),
    .b      (q.opnd),
    .cin    (is_add_carry & q.flags.c),
    .op_and (alu_and),
    .result (alu_res),
    .flags  (alu_flags),
    .upd    (alu_upd)
  );

  // data address: access bank override or bank select register
  function automatic logic [DADDR_W-1:0] data_addr(
    input logic [15:0] iw,
    input logic [3:0]  bsel
  );
    logic [3:0] hi;
    hi = bsel;
    if (!iw[ACCESS_BIT]) begin
      hi = iw[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK;
    end
    return {hi, iw[7:0]};
  endfunction : data_addr

  // byte-lane merge for partial axi writes
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [PC_W-1:0] br_target;
  logic [31:0]     wv;
  logic            accept;

  always_comb begin
    d         = q;
    d.df.wr_en = 1'b0;
    wv        = 32'h00000000;
    accept    = (q.phase == PH_Q1) && !q.idle_cyc && q.run && instr_valid;
    br_target = q.pc + {{(PC_W-9){q.ir[7]}}, q.ir[7:0], 1'b0};

    // axi write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      unique case (q.aw_addr)
        OFS_CTRL: begin
          wv    = merge({31'h0, q.run}, q.w_data, q.w_strb);
          d.run = wv[CTRL_RUN_BIT];
        end
        OFS_STATUS: begin
          wv      = merge({27'h0, q.flags}, q.w_data, q.w_strb);
          d.flags = wv[4:0];
        end
        OFS_ACC: begin
          wv    = merge({24'h0, q.acc}, q.w_data, q.w_strb);
          d.acc = wv[7:0];
        end
        OFS_BANK: begin
          wv     = merge({28'h0, q.bank}, q.w_data, q.w_strb);
          d.bank = wv[3:0];
        end
        OFS_PC: begin
          wv   = merge({11'h0, q.pc}, q.w_data, q.w_strb);
          d.pc = wv[PC_W-1:0];
        end
        OFS_RETIRED: ;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // axi read: one outstanding, data registered
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL:    d.rdata = {31'h0, q.run};
        OFS_STATUS:  d.rdata = {27'h0, q.flags};
        OFS_ACC:     d.rdata = {24'h0, q.acc};
        OFS_BANK:    d.rdata = {28'h0, q.bank};
        OFS_PC:      d.rdata = {11'h0, q.pc};
        OFS_RETIRED: d.rdata = q.retired;
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // execute: later assignments win over software writes in one cycle
    unique case (q.phase)
      PH_Q1: begin
        if (q.idle_cyc) begin
          d.phase = PH_Q2;
        end else if (accept) begin
          d.ir      = instr_word;
          d.pc      = q.pc + PC_STEP;
          d.df.addr = data_addr(instr_word, q.bank);
          d.phase   = PH_Q2;
        end
      end
      PH_Q2: begin
        if (!q.idle_cyc) begin
          // literal ops read the immediate, file ops the register
          d.opnd = is_lit_op ? q.ir[7:0] : df_rd_data;
        end
        d.phase = PH_Q3;
      end
      PH_Q3: begin
        d.take = 1'b0;
        if (!q.idle_cyc) begin
          if (is_lit_op) begin
            d.acc = alu_res;
          end
          if (is_file_op) begin
            if (q.ir[DEST_BIT]) begin
              d.df.wr_en   = 1'b1;
              d.df.wr_data = alu_res;
            end else begin
              d.acc = alu_res;
            end
          end
          if (is_lit_op || is_file_op) begin
            for (int i = 0; i < 5; i++) begin
              if (alu_upd[i]) begin
                d.flags[i] = alu_flags[i];
              end
            end
          end
          if (is_br_carry && q.flags.c) begin
            d.take = 1'b1;
            d.pc   = br_target;
          end
        end
        d.phase = PH_Q4;
      end
      PH_Q4: begin
        d.phase    = PH_Q1;
        d.take     = 1'b0;
        // a taken branch owes one whole idle cycle
        d.idle_cyc = q.take && !q.idle_cyc;
        if (!q.idle_cyc) begin
          d.retired = q.retired + 32'h00000001;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST_STATE;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // outputs
  assign instr_ready   = (q.phase == PH_Q1) && !q.idle_cyc && q.run;
  assign pc            = q.pc;
  assign df_req        = q.df;
  assign s_axi_awready = !q.aw_held;
  assign s_axi_wready  = !q.w_held;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

endmodule : acb_core
`default_nettype wire

// ### src/acb_pkg.sv
// constants and carrier types for the add/and/branch execute block
// assumes a single aclk domain and an axi4-lite master on the register side
`default_nettype none
package acb_pkg;

  // widths
  localparam int PC_W     = 21;
  localparam int DADDR_W  = 12;
  localparam int AXI_AW   = 8;

  // axi4-lite register byte offsets
  localparam logic [AXI_AW-1:0] OFS_CTRL    = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS  = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_ACC     = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_BANK    = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_PC      = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_RETIRED = 8'h14;

  // field positions
  localparam int CTRL_RUN_BIT = 0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reset values
  localparam logic             RST_RUN  = 1'h1;
  localparam logic [7:0]       RST_ACC  = 8'h00;
  localparam logic [3:0]       RST_BANK = 4'h0;
  localparam logic [PC_W-1:0]  RST_PC   = 21'h000000;

  // opcode patterns
  localparam logic [7:0] OPC_ADD_LIT  = 8'h0f;
  localparam logic [7:0] OPC_AND_LIT  = 8'h0b;
  localparam logic [7:0] OPC_BR_CARRY = 8'he2;
  localparam logic [5:0] OPC_ADD_FILE = 6'h09;
  localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;

  // instruction field positions
  localparam int DEST_BIT   = 9;
  localparam int ACCESS_BIT = 8;

  // fixed access bank: low half in bank lo, high half in bank hi
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // program counter step per instruction word, in bytes
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // arithmetic flags; bit order is the status register layout
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } acb_flags_t;

  // request toward the data register file
  typedef struct packed {
    logic [DADDR_W-1:0] addr;
    logic               wr_en;
    logic [7:0]         wr_data;
  } acb_df_req_t;

  // quarter phases of one instruction cycle, gray along the loop
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } acb_phase_t;

endpackage : acb_pkg
`default_nettype wire
